// ===== hdl/adcslc_pkg.sv
// constants for the conversion sequence launch control block
// assumes an apb master on the system clock and an external conversion engine
package adcslc_pkg;
    localparam logic [31:0] ADDR_SEQ_CTRL   = 32'h4001c008;
    localparam logic [31:0] ADDR_SEQ_RESULT = 32'h4001c010;
    localparam logic [31:0] ADDR_SEQ_FLAGS  = 32'h4001c0f0;

    localparam int CTRL_CHAN_LSB = 0;
    localparam int CTRL_CHAN_MSB = 11;
    localparam int CTRL_TSEL_LSB = 12;
    localparam int CTRL_TSEL_MSB = 14;
    localparam int CTRL_EDGE     = 18;
    localparam int CTRL_BYPASS   = 19;
    localparam int CTRL_LAUNCH   = 26;
    localparam int CTRL_BURST    = 27;
    localparam int CTRL_STEP     = 28;
    localparam int CTRL_MODE     = 30;
    localparam int CTRL_ENA      = 31;

    localparam int RES_DATA_LSB  = 4;
    localparam int RES_DATA_MSB  = 15;
    localparam int RES_CHAN_LSB  = 26;
    localparam int RES_CHAN_MSB  = 29;
    localparam int RES_OVR       = 30;
    localparam int RES_VALID     = 31;

    localparam int FLG_SEQDONE   = 0;
    localparam int FLG_OVR_EN    = 1;
    localparam int FLG_BUSY      = 2;

    localparam int NUM_CHAN      = 12;
    localparam int NUM_TRIG      = 8;
    localparam logic [3:0] CHAN_FIRST = 4'h0;
    localparam logic [3:0] CHAN_STEP  = 4'h1;
    localparam logic [31:0] RESET_WORD = 32'h00000000;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_START = 2'b01,
        ST_BUSY  = 2'b11
    } adcslc_state_t;
endpackage

// ===== hdl/adcslc_pick_if.sv
// channel search request and answer between the control and a picker
// assumes one picker module per interface instance
`timescale 1ns/1ps
interface adcslc_pick_if;
    logic [11:0] mask;
    logic [3:0]  fromPos;
    logic [3:0]  chan;
    logic        found;
    modport user   (output mask, output fromPos, input chan, input found);
    modport picker (input mask, input fromPos, output chan, output found);
endinterface

// ===== hdl/adcslc_chan_pick.sv
// finds the lowest enabled channel at or above a start position
// assumes the start position may run one past the highest channel
`timescale 1ns/1ps
module adcslc_chan_pick
    import adcslc_pkg::*;
(
    adcslc_pick_if.picker pick
);
    logic [3:0] hitChan;
    logic       hit;

    // lowest set bit not below the start position
    always_comb begin
        hitChan = CHAN_FIRST;
        hit     = 1'b0;
        for (int i = NUM_CHAN - 1; i >= 0; i--) begin
            if (pick.mask[i] && (4'(i) >= pick.fromPos)) begin
                hitChan = 4'(i);
                hit     = 1'b1;
            end
        end
    end

    assign pick.chan  = hitChan;
    assign pick.found = hit;
endmodule

// ===== hdl/adcslc_launch_ctrl.sv
// sequence launch control: apb registers, triggers, channel order, flags
// assumes synchronous trigger inputs and an engine that answers each start once
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
module adcslc_launch_ctrl
    import adcslc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [7:0]  hwTrig,
    output logic             convStart,
    output logic      [3:0]  convChan,
    input  wire logic        convDone,
    input  wire logic [11:0] convResult,
    output logic             seqIntFlag,
    output logic             ovrIrqReq
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    adcslc_state_t stateFf, nxtState;
    logic [11:0] chanMaskFf;
    logic [2:0]  trigSelFf;
    logic        edgeSelFf, bypassFf, burstFf, stepFf, modeFf, enaFf;
    logic        launchReqFf, prevTrigFf, seqDoneFf, ovrEnFf;
    logic [3:0]  posFf, nxtPos, curChanFf, nxtChan;
    logic [11:0] resultFf;
    logic [3:0]  resChanFf;
    logic        validFf, overrunFf;
    logic [31:0] prdataFf;
    logic        preadyFf, pslverrFf, convStartFf, seqIntFf, ovrIrqFf;
    adcslc_pick_if pickPos ();
    adcslc_pick_if pickLow ();
    adcslc_pick_if pickNext ();

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    wire        accessPh  = psel && penable;
    wire        apbDone   = accessPh && preadyFf;
    wire        hitCtrl   = (paddr == ADDR_SEQ_CTRL);
    wire        hitRes    = (paddr == ADDR_SEQ_RESULT);
    wire        hitFlg    = (paddr == ADDR_SEQ_FLAGS);
    wire        mapped    = hitCtrl || hitRes || hitFlg;
    wire        wrCtrl    = apbDone && pwrite && hitCtrl;
    wire        wrFlg     = apbDone && pwrite && hitFlg;
    wire        rdRes     = apbDone && !pwrite && hitRes;
    wire        doneClr   = wrFlg && pwdata[FLG_SEQDONE];
    wire [31:0] ctrlWord  = {enaFf, modeFf, 1'b0, stepFf, burstFf, 1'b0, 6'h00,
                             bypassFf, edgeSelFf, 3'h0, trigSelFf, chanMaskFf};
    wire [31:0] resWord   = {validFf, overrunFf, resChanFf, 10'h000, resultFf, 4'h0};
    wire [31:0] flgWord   = {29'h00000000, (stateFf != ST_IDLE), ovrEnFf, seqDoneFf};
    wire [31:0] rdMux     = hitCtrl ? ctrlWord : hitRes ? resWord : hitFlg ? flgWord
                                    : RESET_WORD;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            preadyFf  <= 1'b0;
            pslverrFf <= 1'b0;
            prdataFf  <= RESET_WORD;
        end else begin
            preadyFf  <= accessPh && !preadyFf;
            pslverrFf <= accessPh && !preadyFf && !mapped;
            if (accessPh && !preadyFf) begin
                prdataFf <= pwrite ? RESET_WORD : rdMux;
            end
        end
    end

    // ----------------------------------------
    // control register
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            chanMaskFf <= 12'h000;
            trigSelFf  <= 3'h0;
            {edgeSelFf, bypassFf, burstFf, stepFf, modeFf, enaFf} <= 6'h00;
            ovrEnFf    <= 1'b0;
        end else begin
            if (wrCtrl) begin
                chanMaskFf <= pwdata[CTRL_CHAN_MSB:CTRL_CHAN_LSB];
                trigSelFf  <= pwdata[CTRL_TSEL_MSB:CTRL_TSEL_LSB];
                edgeSelFf  <= pwdata[CTRL_EDGE];
                bypassFf   <= pwdata[CTRL_BYPASS];
                burstFf    <= pwdata[CTRL_BURST];
                stepFf     <= pwdata[CTRL_STEP];
                modeFf     <= pwdata[CTRL_MODE];
                enaFf      <= pwdata[CTRL_ENA];
            end
            if (wrFlg) begin
                ovrEnFf <= pwdata[FLG_OVR_EN];
            end
        end
    end

    // ----------------------------------------
    // triggers
    // ----------------------------------------
    // launch bit lives one cycle, after the enable of the same write is in place
    wire rawTrig   = hwTrig[trigSelFf];
    wire effTrig   = enaFf && (edgeSelFf ? rawTrig : !rawTrig);
    wire hwEdge    = effTrig && !prevTrigFf;
    wire trigEvent = hwEdge || launchReqFf;
    wire idle      = (stateFf == ST_IDLE);
    wire launch    = idle && enaFf && pickLow.found
                     && (burstFf || trigEvent);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            launchReqFf <= 1'b0;
            prevTrigFf  <= 1'b0;
        end else begin
            launchReqFf <= wrCtrl && pwdata[CTRL_LAUNCH];
            prevTrigFf  <= effTrig;
        end
    end

    // ----------------------------------------
    // channel order
    // ----------------------------------------
    assign pickPos.mask     = chanMaskFf;
    assign pickPos.fromPos  = posFf;
    assign pickLow.mask     = chanMaskFf;
    assign pickLow.fromPos  = CHAN_FIRST;
    assign pickNext.mask    = chanMaskFf;
    assign pickNext.fromPos = 4'(curChanFf + CHAN_STEP);

    adcslc_chan_pick uPickPos  (.pick(pickPos));
    adcslc_chan_pick uPickLow  (.pick(pickLow));
    adcslc_chan_pick uPickNext (.pick(pickNext));

    wire [3:0] launchChan = pickPos.found ? pickPos.chan : pickLow.chan;
    wire       passEnd    = !pickNext.found;
    wire       busyDone   = (stateFf == ST_BUSY) && convDone;

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_comb begin
        nxtState = stateFf;
        nxtChan  = curChanFf;
        nxtPos   = posFf;
        case (stateFf)
            ST_IDLE: begin
                if (launch) begin
                    nxtState = ST_START;
                    nxtChan  = launchChan;
                end
            end
            ST_START: begin
                nxtState = ST_BUSY;
            end
            ST_BUSY: begin
                if (convDone) begin
                    nxtPos = passEnd ? CHAN_FIRST : 4'(curChanFf + CHAN_STEP);
                    if (!enaFf) begin
                        nxtState = ST_IDLE;
                    end else if (passEnd) begin
                        nxtState = burstFf ? ST_START : ST_IDLE;
                        nxtChan  = pickLow.chan;
                    end else if (stepFf && !burstFf) begin
                        nxtState = ST_IDLE;
                    end else begin
                        nxtState = ST_START;
                        nxtChan  = pickNext.chan;
                    end
                end
            end
            default: begin
                nxtState = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stateFf     <= ST_IDLE;
            posFf       <= CHAN_FIRST;
            curChanFf   <= CHAN_FIRST;
            convStartFf <= 1'b0;
        end else begin
            stateFf     <= nxtState;
            posFf       <= nxtPos;
            curChanFf   <= nxtChan;
            convStartFf <= (nxtState == ST_START);
        end
    end

    // ----------------------------------------
    // result and flags
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            resultFf  <= 12'h000;
            resChanFf <= 4'h0;
            validFf   <= 1'b0;
            overrunFf <= 1'b0;
            seqDoneFf <= 1'b0;
        end else begin
            if (busyDone) begin
                resultFf  <= convResult;
                resChanFf <= curChanFf;
                validFf   <= 1'b1;
                overrunFf <= (validFf || overrunFf) && !rdRes;
            end else if (rdRes) begin
                validFf   <= 1'b0;
                overrunFf <= 1'b0;
            end
            if (busyDone && passEnd) begin
                seqDoneFf <= 1'b1;
            end else if (doneClr) begin
                seqDoneFf <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            seqIntFf <= 1'b0;
            ovrIrqFf <= 1'b0;
        end else begin
            seqIntFf <= modeFf ? seqDoneFf : validFf;
            ovrIrqFf <= !modeFf && ovrEnFf && overrunFf;
        end
    end

    assign prdata     = prdataFf;
    assign pready     = preadyFf;
    assign pslverr    = pslverrFf;
    assign convStart  = convStartFf;
    assign convChan   = curChanFf;
    assign seqIntFlag = seqIntFf;
    assign ovrIrqReq  = ovrIrqFf;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence sLastConv;
        busyDone && passEnd && enaFf;
    endsequence
    sequence sRestart;
        convStart && (convChan == $past(pickLow.chan));
    endsequence

    a_launch_reads_zero: assert property (
        (accessPh && !preadyFf && !pwrite && hitCtrl) |=> !prdata[CTRL_LAUNCH])
        else $error("launch bit read back as one");
    a_disabled_no_start: assert property (
        (idle && !enaFf) |=> !convStart)
        else $error("start issued while disabled");
    a_burst_restart: assert property (
        (sLastConv and burstFf) |=> sRestart)
        else $error("burst did not restart at lowest channel");
    a_step_single_conv: assert property (
        (busyDone && enaFf && stepFf && !burstFf) |=> (stateFf == ST_IDLE) [*2])
        else $error("single step converted more than one channel");
    a_valid_on_load: assert property (
        busyDone |=> validFf ##1 (seqIntFlag || modeFf))
        else $error("result valid not set after conversion");
    a_overrun_on_load: assert property (
        (busyDone && validFf && !rdRes) |=> overrunFf)
        else $error("overrun not set on load over valid result");
    a_pass_flag_hold: assert property (
        (modeFf && seqDoneFf && !doneClr) |=> seqDoneFf)
        else $error("pass flag dropped without clear");
    a_mode_ovr_gate: assert property (
        (modeFf && $stable(modeFf)) |=> !ovrIrqReq)
        else $error("overrun request raised in pass flag mode");
    a_halt_on_disable: assert property (
        (busyDone && !enaFf) |=> (stateFf == ST_IDLE) && !convStart)
        else $error("sequence continued after disable");
    a_busy_no_launch: assert property (
        (!idle && launchReqFf) |=> !launchReqFf && !(convStart && $past(stateFf) == ST_IDLE))
        else $error("launch accepted while busy");
    a_soft_launch_start: assert property (
        (idle && launchReqFf && enaFf && pickLow.found) |=> convStart && (convChan == $past(launchChan)))
        else $error("software launch did not start a conversion");
    a_trig_edge_start: assert property (
        (idle && hwEdge && pickLow.found) |=> convStart)
        else $error("trigger edge did not start a conversion");
    a_pass_continues: assert property (
        (busyDone && enaFf && !stepFf && !passEnd) |=> convStart)
        else $error("pass stopped before its last channel");
    a_step_wraps_low: assert property (
        (busyDone && passEnd) |=> (posFf == CHAN_FIRST))
        else $error("position not back at first channel after pass");
    a_flag_tracks_valid: assert property (
        !modeFf |=> (seqIntFlag == $past(validFf)))
        else $error("sequence flag does not follow result valid");
    a_ovr_feeds_req: assert property (
        (!modeFf && ovrEnFf) |=> (ovrIrqReq == $past(overrunFf)))
        else $error("overrun request does not follow overrun flag");
    a_no_trig_no_start: assert property (
        (idle && !launchReqFf && !hwEdge && !burstFf) |=> !convStart)
        else $error("start issued without a trigger");
endmodule

// ===== verification/tb.sv
// testbench for the sequence launch control block
// assumes one apb wait state and a behavioural conversion engine kept here
`timescale 1ns/1ps
module tb
    import adcslc_pkg::*;
;
    // ------------------------------------------------
    // signals and dut
    // ------------------------------------------------
    localparam logic [31:0] ENA  = 32'h80000000;
    localparam logic [31:0] MODE = 32'h40000000;
    localparam logic [31:0] STEP = 32'h10000000;
    localparam logic [31:0] BRST = 32'h08000000;
    localparam logic [31:0] GO   = 32'h04000000;
    localparam logic [31:0] RISE = 32'h00040000;
    localparam logic [31:0] TS   = 32'h00003000;
    localparam logic [31:0] M    = 32'h000000a4;
    logic        clk;
    logic        rst_b;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  hwTrig;
    logic        convStart;
    logic [3:0]  convChan;
    logic        convDone;
    logic [11:0] convResult;
    logic        seqIntFlag;
    logic        ovrIrqReq;
    logic [31:0] rdData;
    logic        errSeen;
    logic [3:0]  curCh;
    logic [3:0]  chans[$];
    logic [3:0]  pat[3] = '{4'h2, 4'h5, 4'h7};
    int          mismatches;
    int          checkCount;
    int          cnt;
    int          lat;

    adcslc_launch_ctrl dut_u (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .hwTrig(hwTrig), .convStart(convStart), .convChan(convChan),
        .convDone(convDone), .convResult(convResult), .seqIntFlag(seqIntFlag),
        .ovrIrqReq(ovrIrqReq));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ------------------------------------------------
    // engine: answers each start after lat cycles
    // ------------------------------------------------
    always @(posedge clk) begin
        convDone <= 1'b0;
        if (cnt == 1) begin
            convDone <= 1'b1;
            convResult <= {8'h5a, curCh};
        end
        if (cnt > 0) begin
            cnt <= cnt - 1;
        end
        if (convStart === 1'b1) begin
            cnt <= lat;
            curCh <= convChan;
            chans.push_back(convChan);
        end
    end

    // ------------------------------------------------
    // tasks
    // ------------------------------------------------
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rdData = prdata;
        errSeen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task waitN(input int n);
        repeat (n) @(posedge clk);
    endtask

    task waitConv(input int n);
        int k;
        k = 0;
        while (chans.size() < n && k < 300) begin
            @(posedge clk);
            k++;
        end
        waitN(3 * lat + 6);
    endtask

    task expSeq(input int n, input int s);
        check("conversions", 32'(chans.size()), 32'(n));
        for (int i = 0; i < chans.size(); i++) begin
            check("channel", {28'h0, chans[i]}, {28'h0, pat[(i + s) % 3]});
        end
        chans.delete();
    endtask

    task finish_test;
        $display("checks %0d mismatches %0d", checkCount, mismatches);
        if (mismatches == 0 && checkCount > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (6000) @(posedge clk);
        mismatches++;
        finish_test;
    end

    // ------------------------------------------------
    // tests
    // ------------------------------------------------
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {hwTrig, convDone, convResult, cnt} = '0;
        hwTrig[0] = 1'b1;
        rst_b = 1'b0;
        lat = 3;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        apb(1'b0, ADDR_SEQ_CTRL, 32'h0);
        check("ctrl reset", rdData, 32'h0);
        apb(1'b0, ADDR_SEQ_FLAGS, 32'h0);
        check("flags reset", rdData, 32'h0);
        check("flag reset", {31'h0, seqIntFlag}, 32'h0);
        apb(1'b0, 32'h4001c00c, 32'h0);
        check("unmapped", {31'h0, errSeen}, 32'h1);
        apb(1'b1, ADDR_SEQ_CTRL, M | GO);
        waitN(20);
        expSeq(0, 0);
        $display("test reset done");
        apb(1'b1, ADDR_SEQ_FLAGS, 32'h2);
        apb(1'b1, ADDR_SEQ_CTRL, ENA | M | GO);
        apb(1'b1, ADDR_SEQ_CTRL, ENA | M | GO);
        waitConv(3);
        expSeq(3, 0);
        apb(1'b0, ADDR_SEQ_CTRL, 32'h0);
        check("ctrl read", rdData, ENA | M);
        check("flag mode0", {31'h0, seqIntFlag}, 32'h1);
        check("ovr req", {31'h0, ovrIrqReq}, 32'h1);
        apb(1'b0, ADDR_SEQ_RESULT, 32'h0);
        check("result", rdData, {2'b11, 4'h7, 10'h0, 12'h5a7, 4'h0});
        apb(1'b0, ADDR_SEQ_RESULT, 32'h0);
        check("result flags", {30'h0, rdData[31:30]}, 32'h0);
        waitN(3);
        check("flag cleared", {31'h0, seqIntFlag}, 32'h0);
        $display("test software pass done");
        apb(1'b1, ADDR_SEQ_CTRL, ENA | MODE | M | GO);
        waitConv(3);
        expSeq(3, 0);
        check("ovr mode1", {31'h0, ovrIrqReq}, 32'h0);
        check("flag mode1", {31'h0, seqIntFlag}, 32'h1);
        apb(1'b1, ADDR_SEQ_FLAGS, 32'h3);
        apb(1'b0, ADDR_SEQ_FLAGS, 32'h0);
        check("done clear", rdData, 32'h2);
        for (int k = 0; k < 6; k++) begin
            apb(1'b1, ADDR_SEQ_CTRL, ENA | STEP | MODE | M | GO);
            waitN(12);
            check("step count", 32'(chans.size()), 32'(k + 1));
            apb(1'b0, ADDR_SEQ_FLAGS, 32'h0);
            check("step done", {31'h0, rdData[0]}, {31'h0, k > 1});
        end
        expSeq(6, 0);
        apb(1'b1, ADDR_SEQ_FLAGS, 32'h1);
        $display("test modes done");
        apb(1'b1, ADDR_SEQ_CTRL, ENA | RISE | TS | M);
        waitN(10);
        hwTrig[3] <= 1'b1;
        waitConv(3);
        expSeq(3, 0);
        apb(1'b1, ADDR_SEQ_CTRL, RISE | TS | M);
        apb(1'b1, ADDR_SEQ_CTRL, ENA | RISE | TS | M);
        waitConv(3);
        expSeq(3, 0);
        apb(1'b1, ADDR_SEQ_CTRL, ENA | TS | M);
        waitN(10);
        hwTrig[3] <= 1'b0;
        waitConv(3);
        expSeq(3, 0);
        $display("test triggers done");
        lat = 12;
        apb(1'b1, ADDR_SEQ_CTRL, ENA | TS | M | GO);
        waitN(2);
        apb(1'b1, ADDR_SEQ_CTRL, TS | M);
        waitN(30);
        expSeq(1, 0);
        hwTrig[3] <= 1'b1;
        apb(1'b1, ADDR_SEQ_CTRL, ENA | TS | M);
        waitN(10);
        expSeq(0, 0);
        hwTrig[3] <= 1'b0;
        waitConv(2);
        expSeq(2, 1);
        lat = 3;
        $display("test halt done");
        apb(1'b1, ADDR_SEQ_CTRL, ENA | BRST | M);
        waitConv(7);
        hwTrig[0] <= 1'b0;
        apb(1'b1, ADDR_SEQ_CTRL, ENA | M);
        waitN(40);
        check("burst runs", {31'h0, chans.size() > 7}, 32'h1);
        check("burst whole", 32'(chans.size() % 3), 32'h0);
        $display("test burst done");
        finish_test;
    end
endmodule
